// File: src/wdt_guarded_control.sv
// watchdog guarded control register, 8-bit up counter and internal reset request.
// assumes software writes whole bytes over classic wishbone; all inputs synchronous to clk.
//
// Contract
// R1: counter permit changes only with inhibit 7 zero
// R2: inhibit bits 7,5,3,1 always read one
// R3: counter writes accepted only while permit set
// R4: register permit changes only with inhibit 5 zero
// R5: run and indicator need register permit
// R6: run changes with inhibit 3 zero, permit set
// R7: counter runs while run set; reset sets run
// R8: indicator changes only with inhibit 1 zero
// R9: overflow with chip reset sets indicator
// R10: indicator survives watchdog's own reset
// R11: pin reset or guarded zero write clears indicator
// R12: software writes whole bytes with inhibit zero
// R13: reset value ones at 7,5,3,2,1
// R14: counter overflow issues internal chip reset
// R15: each protected bit judged by own inhibit
module wdt_guarded_control
    import wdt_guard_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire wdt_guard_pkg::wb_req_t wb_req,
    output wdt_guard_pkg::wb_rsp_t      wb_rsp,
    output logic             chip_reset_req
);
    import wdt_guard_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // stored state
    logic       counter_write_permit;   // counter write permission
    logic       register_write_permit;  // run/indicator write permission
    logic       watchdog_run;           // counting enabled
    logic       watchdog_reset_indicator; // sticky: watchdog reset happened
    logic [7:0] watchdog_counter;       // the up counter
    logic [2:0] chip_reset_count;       // internal reset pulse timer
    logic       ack;                    // answer flag

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        req      = wb_req.cyc & wb_req.stb & ~ack;  // one ack per request
    wire        wr_lane0 = req & wb_req.we & wb_req.sel[0];
    wire [7:0]  wdata    = wb_req.dat[7:0];
    wire        hit_ctrl = wb_req.adr == guarded_control_off;
    wire        hit_cnt  = wb_req.adr == counter_off;
    wire        hit_stat = wb_req.adr == wdt_status_off;
    wire        wr_ctrl  = wr_lane0 & hit_ctrl;
    // each protected bit sees only its own inhibit bit in the same write
    wire        upd_cwp  = wr_ctrl & ~wdata[counter_permit_inhibit_bit];            // R1 R15
    wire        upd_rwp  = wr_ctrl & ~wdata[register_permit_inhibit_bit];           // R4 R15
    wire        upd_run  = wr_ctrl & register_write_permit
                           & ~wdata[run_inhibit_bit];                               // R5 R6 R15
    wire        upd_ind  = wr_ctrl & register_write_permit
                           & ~wdata[reset_indicator_inhibit_bit];                   // R5 R8 R15
    wire        wr_cnt   = wr_lane0 & hit_cnt & counter_write_permit;               // R3
    wire        overflow = watchdog_run & (watchdog_counter == counter_top)
                           & ~wr_cnt;                                               // R14
    wire        in_chip_reset = chip_reset_count != 3'd0;

    // read view: inhibit bits forced to one
    wire [7:0] ctrl_view = inhibit_mask
                         | {1'b0, counter_write_permit, 1'b0, register_write_permit,
                            1'b0, watchdog_run, 1'b0, watchdog_reset_indicator};    // R2
    wire [31:0] rdata = hit_ctrl ? {24'h0000_00, ctrl_view}
                      : hit_cnt  ? {24'h0000_00, watchdog_counter}
                      : hit_stat ? {31'h0000_0000, in_chip_reset}
                      : 32'h0000_0000;   // unmapped reads as zero, still acked

    ////////////////////////////////////////////////////////////////////////
    // wishbone answer: one wait-free cycle after request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack        <= 1'b0;
            wb_rsp.ack <= 1'b0;
            wb_rsp.dat <= 32'h0000_0000;
        end else begin
            ack        <= req;
            wb_rsp.ack <= req;
            wb_rsp.dat <= req ? rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // guarded control bits; the pin reset loads the documented values
    // the internal chip reset below does not touch the indicator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            counter_write_permit     <= control_reset[counter_write_permit_bit];     // R13
            register_write_permit    <= control_reset[register_write_permit_bit];    // R13
            watchdog_run             <= control_reset[watchdog_run_bit];             // R7 R13
            watchdog_reset_indicator <= control_reset[watchdog_reset_indicator_bit]; // R11
        end else begin
            if (upd_cwp)
                counter_write_permit <= wdata[counter_write_permit_bit];             // R1
            if (upd_rwp)
                register_write_permit <= wdata[register_write_permit_bit];           // R4
            if (upd_run)
                watchdog_run <= wdata[watchdog_run_bit];                             // R6
            // overflow set wins over a software clear in the same cycle
            if (overflow)
                watchdog_reset_indicator <= 1'b1;                                    // R9 R10
            else if (upd_ind)
                watchdog_reset_indicator <= wdata[watchdog_reset_indicator_bit];     // R11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter: software load has priority over counting
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            watchdog_counter <= counter_reset;
        else if (wr_cnt)
            watchdog_counter <= wdata;                                               // R3
        else if (watchdog_run)
            watchdog_counter <= watchdog_counter + 8'h01;                            // R7
    end

    ////////////////////////////////////////////////////////////////////////
    // internal reset request pulse, stretched for the rest of the chip
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_reset_count <= 3'd0;
            chip_reset_req   <= 1'b0;
        end else begin
            if (overflow)
                chip_reset_count <= 3'(chip_reset_cycles);                           // R14
            else if (in_chip_reset)
                chip_reset_count <= chip_reset_count - 3'd1;
            chip_reset_req <= overflow | (chip_reset_count > 3'd1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_counter_permit_guard: assert property (@(posedge clk) disable iff (rst) // R1
        (wr_ctrl & wdata[counter_permit_inhibit_bit]) |=> $stable(counter_write_permit))
        else $error("counter permit changed with inhibit set");
    a_inhibit_read_one: assert property (@(posedge clk) disable iff (rst) // R2
        (req & ~wb_req.we & hit_ctrl) |=> ((wb_rsp.dat[7:0] & inhibit_mask) == inhibit_mask))
        else $error("inhibit bit read as zero");
    a_counter_write_blocked: assert property (@(posedge clk) disable iff (rst) // R3
        (wr_lane0 & hit_cnt & ~counter_write_permit & ~watchdog_run) |=> $stable(watchdog_counter))
        else $error("counter written without permit");
    a_register_permit_guard: assert property (@(posedge clk) disable iff (rst) // R4
        (wr_ctrl & ~wdata[register_permit_inhibit_bit])
        |=> register_write_permit == $past(wdata[register_write_permit_bit]))
        else $error("register permit missed update");
    a_run_needs_permit: assert property (@(posedge clk) disable iff (rst) // R5
        (wr_ctrl & ~register_write_permit) |=> $stable(watchdog_run))
        else $error("run changed without permit");
    a_run_update: assert property (@(posedge clk) disable iff (rst) // R6
        upd_run |=> watchdog_run == $past(wdata[watchdog_run_bit]))
        else $error("run bit missed update");
    a_counter_counts: assert property (@(posedge clk) disable iff (rst) // R7
        (watchdog_run & ~wr_cnt) |=> watchdog_counter == $past(watchdog_counter) + 8'h01)
        else $error("counter did not advance");
    a_indicator_guard: assert property (@(posedge clk) disable iff (rst) // R8
        (wr_ctrl & wdata[reset_indicator_inhibit_bit] & ~overflow) |=> $stable(watchdog_reset_indicator))
        else $error("indicator changed with inhibit set");
    a_overflow_sets_ind: assert property (@(posedge clk) disable iff (rst) // R9
        overflow |=> watchdog_reset_indicator ##0 chip_reset_req [*3])
        else $error("overflow did not flag reset");
    c_overflow: cover property (@(posedge clk) disable iff (rst) overflow);
    c_run_stop: cover property (@(posedge clk) disable iff (rst) upd_run & ~wdata[watchdog_run_bit]);
    c_counter_load: cover property (@(posedge clk) disable iff (rst) wr_cnt);
    c_ind_clear: cover property (@(posedge clk) disable iff (rst) upd_ind & watchdog_reset_indicator);

    ////////////////////////////////////////////////////////////////////////
    // further checks, grouped by the interface they guard
    // these look only at what this block drives, never at the bus master;
    // a master that breaks the classic handshake is not caught here.
    // the permit checks compare against the permit value before the write,
    // because a single byte may both change the permit and touch run or
    // the indicator, and only the old permit may decide the latter.
    // the overflow set of the indicator wins over a software clear in the
    // same cycle, so every indicator check masks the overflow cycle out.
    // the internal reset pulse may be retriggered by a counter load of the
    // top value during the pulse; the pulse checks allow for that.
    // nothing here tests for unknown values; reset covers every flop.
    // the pin reset check below runs without a disable condition on purpose,
    // since it looks at the first edge after the pin is released.

    ////////////////////////////////////////////////////////////////////////
    // bus answer checks

    // ack stands for exactly one cycle,
    // even when the master keeps its strobe up
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst) // R12
        wb_rsp.ack |=> ~wb_rsp.ack)
        else $error("ack stood longer than one cycle");

    // every taken request is answered
    // on the very next edge, with no wait state
    a_ack_after_take: assert property (@(posedge clk) disable iff (rst) // R12
        req |=> wb_rsp.ack)
        else $error("taken request not acked");

    // read data is zero whenever ack is low,
    // so a late sampler sees no stale value
    a_dat_zero_idle: assert property (@(posedge clk) disable iff (rst) // R2
        ~wb_rsp.ack |-> (wb_rsp.dat == 32'h0000_0000))
        else $error("read data not zero outside ack");

    // unmapped places read zero
    // and are still acked
    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // R2
        (req & ~hit_ctrl & ~hit_cnt & ~hit_stat) |=> (wb_rsp.dat == 32'h0000_0000))
        else $error("unmapped read not zero");

    // only the low byte carries data;
    // upper read bits are always zero
    a_upper_bits_zero: assert property (@(posedge clk) disable iff (rst) // R2
        wb_rsp.ack |-> (wb_rsp.dat[31:8] == 24'h0000_00))
        else $error("upper read bits not zero");

    ////////////////////////////////////////////////////////////////////////
    // counter checks

    // a permitted counter write lands
    // on the next edge, counting waits one cycle
    a_counter_load: assert property (@(posedge clk) disable iff (rst) // R3
        wr_cnt |=> (watchdog_counter == $past(wdata)))
        else $error("counter write did not land");

    // a stopped counter holds its value
    // unless software loads it
    a_counter_holds: assert property (@(posedge clk) disable iff (rst) // R7
        (~watchdog_run & ~wr_cnt) |=> $stable(watchdog_counter))
        else $error("stopped counter moved");

    // an overflow wraps the counter
    // back to zero on the next edge
    a_wrap_to_zero: assert property (@(posedge clk) disable iff (rst) // R14
        overflow |=> (watchdog_counter == counter_reset))
        else $error("counter did not wrap");

    ////////////////////////////////////////////////////////////////////////
    // guarded control bit checks

    // counter permit takes the written value
    // when its inhibit bit is written zero
    a_cwp_update: assert property (@(posedge clk) disable iff (rst) // R1
        upd_cwp |=> (counter_write_permit == $past(wdata[counter_write_permit_bit])))
        else $error("counter permit missed update");

    // register permit holds
    // when its inhibit bit is written one
    a_rwp_guard: assert property (@(posedge clk) disable iff (rst) // R4
        (wr_ctrl & wdata[register_permit_inhibit_bit]) |=> $stable(register_write_permit))
        else $error("register permit changed with inhibit set");

    // run holds
    // when its inhibit bit is written one
    a_run_guard: assert property (@(posedge clk) disable iff (rst) // R6
        (wr_ctrl & wdata[run_inhibit_bit]) |=> $stable(watchdog_run))
        else $error("run changed with inhibit set");

    // indicator ignores software
    // while register permit is clear
    a_ind_needs_permit: assert property (@(posedge clk) disable iff (rst) // R5
        (wr_ctrl & ~register_write_permit & ~overflow) |=> $stable(watchdog_reset_indicator))
        else $error("indicator changed without permit");

    // indicator is sticky: only an overflow or a guarded write moves it,
    // so the internal chip reset leaves it alone
    a_ind_sticky: assert property (@(posedge clk) disable iff (rst) // R10
        (~overflow & ~upd_ind) |=> $stable(watchdog_reset_indicator))
        else $error("indicator moved without cause");

    // a guarded zero write clears the indicator
    // when no overflow falls in the same cycle
    a_ind_clear: assert property (@(posedge clk) disable iff (rst) // R11
        (upd_ind & ~wdata[watchdog_reset_indicator_bit] & ~overflow) |=> ~watchdog_reset_indicator)
        else $error("indicator not cleared");

    // a write without the low byte lane
    // leaves both permits alone
    a_lane_gate: assert property (@(posedge clk) disable iff (rst) // R15
        (req & wb_req.we & ~wb_req.sel[0])
        |=> ($stable(counter_write_permit) & $stable(register_write_permit)))
        else $error("write without lane changed a permit");

    ////////////////////////////////////////////////////////////////////////
    // internal reset request checks

    // the request stands for the full pulse length;
    // a retrigger only stretches it
    a_pulse_length: assert property (@(posedge clk) disable iff (rst) // R14
        overflow |=> chip_reset_req [*4])
        else $error("internal reset pulse too short");

    // the request falls once the pulse timer
    // reaches its last count
    a_pulse_ends: assert property (@(posedge clk) disable iff (rst) // R14
        ((chip_reset_count == 3'd1) & ~overflow) |=> ~chip_reset_req)
        else $error("internal reset pulse too long");

    // the status place shows a pulse in progress
    // to a read taken during it
    a_status_view: assert property (@(posedge clk) disable iff (rst) // R14
        (req & ~wb_req.we & hit_stat & in_chip_reset) |=> wb_rsp.dat[0])
        else $error("status missed internal reset");

    ////////////////////////////////////////////////////////////////////////
    // pin reset check

    // after the pin is released the control bits hold their reset values:
    // run set, indicator and both permits clear, counter at zero
    a_pin_reset_values: assert property (@(posedge clk) // R13
        $fell(rst) |-> (watchdog_run & ~watchdog_reset_indicator & ~counter_write_permit
                        & ~register_write_permit & (watchdog_counter == counter_reset)))
        else $error("control bits not at reset values");

    // end of checks
endmodule

// File: src/wdt_guard_pkg.sv
// package for the guarded watchdog control register and counter.
// assumes a classic wishbone slave with 32-bit data, one clock, async reset.
package wdt_guard_pkg;
    // register byte offsets
    localparam logic [3:0] guarded_control_off = 4'h0;
    localparam logic [3:0] counter_off         = 4'h4;
    localparam logic [3:0] wdt_status_off      = 4'h8;
    // field positions in the guarded control register
    localparam int counter_permit_inhibit_bit  = 7;
    localparam int counter_write_permit_bit    = 6;
    localparam int register_permit_inhibit_bit = 5;
    localparam int register_write_permit_bit   = 4;
    localparam int run_inhibit_bit             = 3;
    localparam int watchdog_run_bit            = 2;
    localparam int reset_indicator_inhibit_bit = 1;
    localparam int watchdog_reset_indicator_bit = 0;
    // inhibit bits always read as one
    localparam logic [7:0] inhibit_mask  = 8'hAA;
    localparam logic [7:0] control_reset = 8'hAE;
    // counter width, top value and internal reset pulse length
    localparam int         counter_width = 8;
    localparam logic [7:0] counter_top   = 8'hFF;
    localparam logic [7:0] counter_reset = 8'h00;
    localparam int         chip_reset_cycles = 4;
    // one wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;
    // slave answer
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;
endpackage

// File: bench/wdt_guarded_control_bench.sv
// bench for the guarded watchdog control register, counter and internal reset request.
// assumes the design answers classic wishbone with a registered one-cycle ack.
module wdt_guarded_control_bench;
    import wdt_guard_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic    clk;             // 50 MHz system clock
    logic    rst;             // stands in for the external reset pin
    wb_req_t req;             // bus request driven by the bench
    wb_rsp_t rsp;             // bus answer from the design
    logic    chip_reset_req;  // internal chip reset request
    int      failures;        // mismatches seen
    int      checks_done;     // comparisons made
    wdt_guarded_control i_dut (.clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp), .chip_reset_req(chip_reset_req));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and shared helpers
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic end_sim;
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; entered right after a rising edge, returns right after one
    task automatic acc(input logic we, input logic [3:0] adr, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h00_0000, d}};
        do begin
            @(posedge clk);
            n++;
        end while (rsp.ack !== 1'b1 && n < 50);
        if (rsp.ack !== 1'b1) begin
            failures++;
            end_sim();
        end
        // ack sampled high at this edge: take the data here, release, then one idle cycle
        q = rsp.dat;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] adr, input logic [7:0] d);
        logic [31:0] q;
        acc(1'b1, adr, d, q);
    endtask
    task automatic rd_chk(input logic [3:0] adr, input logic [7:0] exp);
        logic [31:0] q;
        acc(1'b0, adr, 8'h00, q);
        check(q, {24'h00_0000, exp});
    endtask
    // difference of two back-to-back counter reads, three cycles apart
    task automatic cnt_step(output logic [7:0] step);
        logic [31:0] a, b;
        acc(1'b0, counter_off, 8'h00, a);
        acc(1'b0, counter_off, 8'h00, b);
        step = b[7:0] - a[7:0];
    endtask
    // waits for the internal reset pulse and measures its length in cycles
    task automatic wait_ovf(output int k);
        int n;
        n = 0;
        k = 0;
        while (chip_reset_req !== 1'b1 && n < 600) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 600) begin
            failures++;
            end_sim();
        end
        while (chip_reset_req === 1'b1 && k < 10) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic sc_reset_and_run;
        logic [7:0] s;
        rd_chk(guarded_control_off, 8'hAE);
        cnt_step(s);
        check({24'h00_0000, s}, 32'h0000_0003);
        rd_chk(4'hC, 8'h00);  // unmapped place reads zero
        rd_chk(wdt_status_off, 8'h00);
    endtask
    task automatic sc_permits;
        logic [7:0]  s;
        logic [31:0] held;
        wr(guarded_control_off, 8'h9A);
        rd_chk(guarded_control_off, 8'hBE);
        wr(guarded_control_off, 8'hA2);
        rd_chk(guarded_control_off, 8'hBA);
        cnt_step(s);
        check({24'h00_0000, s}, 32'h0000_0000);
        acc(1'b0, counter_off, 8'h00, held);
        wr(counter_off, 8'h55);
        rd_chk(counter_off, held[7:0]);
        wr(guarded_control_off, 8'h6A);
        wr(guarded_control_off, 8'hAA);
        rd_chk(guarded_control_off, 8'hFA);
        wr(counter_off, 8'h55);
        rd_chk(counter_off, 8'h55);
    endtask
    task automatic sc_multi_bit;
        wr(guarded_control_off, 8'h00);
        rd_chk(guarded_control_off, 8'hAA);
        wr(guarded_control_off, 8'h04);
        rd_chk(guarded_control_off, 8'hAA);
        wr(guarded_control_off, 8'h14);
        rd_chk(guarded_control_off, 8'hBA);
        wr(guarded_control_off, 8'h14);
        rd_chk(guarded_control_off, 8'hBE);
    endtask
    task automatic sc_overflow;
        int k;
        wait_ovf(k);
        check(32'(k), 32'(chip_reset_cycles));
        rd_chk(guarded_control_off, 8'hBF);
        rd_chk(guarded_control_off, 8'hBF);
        wr(guarded_control_off, 8'hAA);
        rd_chk(guarded_control_off, 8'hBF);
        wr(guarded_control_off, 8'hA8);
        rd_chk(guarded_control_off, 8'hBE);
        wait_ovf(k);
        rd_chk(guarded_control_off, 8'hBF);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(guarded_control_off, 8'hAE);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: reset held three cycles, requests start one cycle after release
    initial begin
        failures = 0;
        checks_done = 0;
        rst = 1'b1;
        req = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        sc_reset_and_run();
        sc_permits();
        sc_multi_bit();
        sc_overflow();
        end_sim();
    end
endmodule
